// file: core/supervisor_pkg.sv
// Constants for the supervisor core; the link-side decoder uses none of them.
// Assumes the system clock ref_clk runs at 100 MHz.
package supervisor_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ       = 100_000_000;
   localparam int unsigned CRYSTAL_HZ       = 32_768;
   localparam int unsigned HOLD_MS          = 250;
   // Crystal ticks for the 250 ms hold windows (rounded up)
   localparam int unsigned HOLD_TICKS       =
      (HOLD_MS * CRYSTAL_HZ + 999) / 1000;
   localparam int unsigned WDOG_TICKS_DEF   = 49_152;
   localparam int unsigned DEBOUNCE_TICKS_DEF = 328;
   localparam int unsigned TICK_W           = 20;
   // Crystal activity: ref_clk cycles without a crystal edge
   localparam int unsigned XTAL_LOSS_CYCLES = 4 * REF_CLK_HZ / CRYSTAL_HZ;
   localparam int unsigned XTAL_W           = 16;
   // ---------------------------------------------------------------
   // Command byte layout
   // ---------------------------------------------------------------
   localparam int unsigned CMD_DIR_BIT      = 7;
   localparam int unsigned CMD_ADDR_W       = 7;
   localparam logic        CMD_DIR_READ     = 1'b0;
   localparam logic        CMD_DIR_WRITE    = 1'b1;
endpackage

// file: core/cmd_byte_decode.sv
// Link-side command byte capture on the serial clock.
// Assumes the serial clock only runs while the select line is high.
module cmd_byte_decode (
   input  wire logic       serial_clk,
   input  wire logic       rstn,
   input  wire logic       sel,
   input  wire logic       serial_in,
   output logic [7:0]      cmd_q,
   output logic            cmd_tog_q
);
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic       first_q;
   logic       frame_rstn;

   // The serial clock stands still between frames, so a cut frame can
   // only be cleaned up by select itself: select low clears the count.
   assign frame_rstn = rstn & sel;

   always_ff @(posedge serial_clk or negedge frame_rstn) begin
      if (!frame_rstn) begin
         bit_cnt_q <= 3'h0;
         shift_q   <= 7'h00;
         first_q   <= 1'b1;
      end else begin
         // Lsb first
         shift_q   <= {serial_in, shift_q[6:1]}; // RULE_14
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7) begin
            first_q <= 1'b0;
         end
      end
   end

   // Only the first byte of a frame is a command; later bytes are data
   always_ff @(posedge serial_clk or negedge rstn) begin
      if (!rstn) begin
         cmd_q     <= 8'h00;
         cmd_tog_q <= 1'b0;
      end else if (sel && first_q && bit_cnt_q == 3'h7) begin
         cmd_q     <= {serial_in, shift_q}; // RULE_14
         cmd_tog_q <= ~cmd_tog_q;
      end
   end
endmodule

// file: core/supervisor_ram_gate_cmd_decode.sv
// Supervisor: reset sequencing, watchdog, pushbutton, SRAM gating,
// interrupt, backup switch and command byte decode.
// Assumes comparator levels and pins are asynchronous to ref_clk.
//
// Notes on behaviour
// [RULE_01] Host holds ram enable low to select SRAM; high blocks both outputs.
// [RULE_02] High byte select low only while upper gate and ram enable low.
// [RULE_03] Low byte select low only while lower gate and ram enable low.
// [RULE_04] Interrupt high while status flag and its enable are both set.
// [RULE_05] Reset on supply fail, watchdog, power-up interval, pushbutton.
// [RULE_06] Reset pin press is debounced, then reset held at least 250 ms.
// [RULE_07] Reset pin is open drain: only pulled low, else released.
// [RULE_08] Host strobes watchdog low each period, else reset is asserted.
// [RULE_09] Timing derives from 32.768 kHz crystal; no crystal, no function.
// [RULE_10] Supply below 2.88 V blocks host accesses and asserts reset.
// [RULE_11] After power-up, inputs ignored until 250 ms delay has elapsed.
// [RULE_12] Supply below 2.7 V or battery switches operation to backup.
// [RULE_13] Supply back in tolerance keeps reset asserted another 250 ms.
// [RULE_14] Each transfer starts with a command byte; bits 0..6 address.
// [RULE_15] Command bit 7 zero reads, one writes the addressed register.
// [RULE_16] Both byte selects held inactive during power transients.
// [RULE_17] Host holds select high through each transfer; idles low.
// [RULE_18] Watchdog and debounce lengths are crystal-tick parameters.
// [RULE_19] Interrupt keeps working while running from backup.
module supervisor_ram_gate_cmd_decode #(
   parameter int unsigned WDOG_TICKS     = supervisor_pkg::WDOG_TICKS_DEF,
   parameter int unsigned DEBOUNCE_TICKS = supervisor_pkg::DEBOUNCE_TICKS_DEF,
   parameter int unsigned HOLD_TICKS     = supervisor_pkg::HOLD_TICKS
) (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       crystal_in,
   output logic            crystal_out,
   input  wire logic       supply_ok,
   input  wire logic       supply_above_switch,
   input  wire logic       ram_enable_in_n,
   input  wire logic       upper_byte_gate_in_n,
   input  wire logic       lower_byte_gate_in_n,
   output logic            high_byte_select_out_n,
   output logic            low_byte_select_out_n,
   output logic            on_backup,
   input  wire logic       watchdog_kick_n,
   input  wire logic       reset_pin_in,
   output logic            reset_pin_out,
   output logic            reset_pin_oe,
   input  wire logic       irq_flag,
   input  wire logic       irq_enable,
   output logic            irq_out,
   input  wire logic       serial_clk,
   input  wire logic       serial_sel,
   input  wire logic       serial_in,
   output logic            cmd_valid,
   output logic            cmd_write,
   output logic [6:0]      cmd_addr,
   output logic            host_access_ok
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   localparam int unsigned NSYNC = 10;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   logic             link_tog;
   logic [7:0]       link_cmd;

   always_ff @(posedge ref_clk or negedge rstn) begin
      // Reset to each pin's idle level: kick and reset pin high, the
      // rest low, so no false crystal tick, toggle or irq follows reset
      if (!rstn) begin
         sync1_q <= 10'h030;
         sync2_q <= 10'h030;
      end else begin
         sync1_q <= {link_tog, serial_sel, irq_enable, irq_flag,
                     reset_pin_in, watchdog_kick_n, supply_above_switch,
                     supply_ok, crystal_in, 1'b0};
         sync2_q <= sync1_q;
      end
   end

   logic xtal_s, ok_s, above_s, kick_n_s, pin_s, flag_s, en_s, tog_s;
   assign xtal_s   = sync2_q[1];
   assign ok_s     = sync2_q[2];
   assign above_s  = sync2_q[3];
   assign kick_n_s = sync2_q[4];
   assign pin_s    = sync2_q[5];
   assign flag_s   = sync2_q[6];
   assign en_s     = sync2_q[7];
   assign tog_s    = sync2_q[9];

   // ---------------------------------------------------------------
   // Crystal tick and presence
   // ---------------------------------------------------------------
   logic                               xtal_d1_q;
   logic                               tick;
   logic [supervisor_pkg::XTAL_W-1:0]  xtal_idle_q;
   logic                               xtal_alive_q;

   assign tick = xtal_s & ~xtal_d1_q; // RULE_09

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xtal_d1_q    <= 1'b0;
         xtal_idle_q  <= '0;
         xtal_alive_q <= 1'b0;
      end else begin
         xtal_d1_q <= xtal_s;
         if (tick) begin
            xtal_idle_q  <= '0;
            xtal_alive_q <= 1'b1;
         end else if (xtal_idle_q ==
               supervisor_pkg::XTAL_W'(supervisor_pkg::XTAL_LOSS_CYCLES)) begin
            xtal_alive_q <= 1'b0; // RULE_09
         end else begin
            xtal_idle_q <= xtal_idle_q + 1'b1;
         end
      end
   end

   // Oscillator drive is the inverted crystal input
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) crystal_out <= 1'b0;
      else crystal_out <= ~xtal_s;
   end

   // ---------------------------------------------------------------
   // Supply sequencing
   // ---------------------------------------------------------------
   logic                         ok_d1_q;
   logic [supervisor_pkg::TICK_W-1:0] pu_cnt_q;
   logic                         pu_busy;
   logic                         powered;

   // Without a running crystal nothing is considered powered
   assign powered = ok_s & xtal_alive_q;                // RULE_10
   assign pu_busy = pu_cnt_q != '0;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ok_d1_q  <= 1'b0;
         pu_cnt_q <= supervisor_pkg::TICK_W'(HOLD_TICKS);
      end else begin
         ok_d1_q <= powered;
         if (!powered) begin
            pu_cnt_q <= supervisor_pkg::TICK_W'(HOLD_TICKS); // RULE_13
         end else if (pu_busy && tick) begin
            pu_cnt_q <= pu_cnt_q - 1'b1;                     // RULE_11
         end
      end
   end

   // Bus, kick, button and command inputs are honoured only after the power-up delay
   logic live;
   assign live = powered & ~pu_busy;                       // RULE_11

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) on_backup <= 1'b1;
      else on_backup <= ~above_s;                          // RULE_12
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   logic                         kick_d1_q;
   logic [supervisor_pkg::TICK_W-1:0] wd_cnt_q;
   logic                         wd_fire;

   assign wd_fire = live && tick &&
      wd_cnt_q == supervisor_pkg::TICK_W'(WDOG_TICKS - 1); // RULE_18

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         kick_d1_q <= 1'b1;
         wd_cnt_q  <= '0;
      end else begin
         kick_d1_q <= kick_n_s;
         if (!live || (kick_d1_q && !kick_n_s) || wd_fire) begin
            wd_cnt_q <= '0;                                // RULE_08
         end else if (tick) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pushbutton debounce and reset pulse
   // ---------------------------------------------------------------
   logic [supervisor_pkg::TICK_W-1:0] db_cnt_q;
   logic [supervisor_pkg::TICK_W-1:0] hold_cnt_q;
   logic                         press;
   logic                         holding;

   assign holding = hold_cnt_q != '0;
   // The pin is our own output too; only sense it while released
   assign press = live && !holding && !pin_s && tick &&
      db_cnt_q == supervisor_pkg::TICK_W'(DEBOUNCE_TICKS - 1); // RULE_06

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         db_cnt_q <= '0;
      end else if (!live || holding || pin_s || press) begin
         db_cnt_q <= '0;
      end else if (tick) begin
         db_cnt_q <= db_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hold_cnt_q <= '0;
      end else if (press || wd_fire) begin
         hold_cnt_q <= supervisor_pkg::TICK_W'(HOLD_TICKS); // RULE_06
      end else if (!powered) begin
         hold_cnt_q <= '0;
      end else if (holding && tick) begin
         hold_cnt_q <= hold_cnt_q - 1'b1;
      end
   end

   // Open drain: drive data is always low, enable pulls the pin
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reset_pin_out <= 1'b0;
         reset_pin_oe  <= 1'b1;
      end else begin
         reset_pin_out <= 1'b0;                            // RULE_07
         reset_pin_oe  <= !powered || pu_busy || holding
                        || wd_fire || press;               // RULE_05
      end
   end

   // ---------------------------------------------------------------
   // SRAM byte selects
   // ---------------------------------------------------------------
   // Combinational pass is avoided for a registered output; one
   // cycle plus sync latency is the price of glitch-free gating.
   logic ce_n_s, ub_n_s, lb_n_s;
   logic [2:0] ram1_q, ram2_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ram1_q <= 3'h7;
         ram2_q <= 3'h7;
      end else begin
         ram1_q <= {ram_enable_in_n, upper_byte_gate_in_n,
                    lower_byte_gate_in_n};
         ram2_q <= ram1_q;
      end
   end
   assign ce_n_s = ram2_q[2];
   assign ub_n_s = ram2_q[1];
   assign lb_n_s = ram2_q[0];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         high_byte_select_out_n <= 1'b1;
         low_byte_select_out_n  <= 1'b1;
      end else begin
         high_byte_select_out_n <= !(live && !ce_n_s && !ub_n_s); // RULE_02 RULE_16
         low_byte_select_out_n  <= !(live && !ce_n_s && !lb_n_s); // RULE_03 RULE_16
      end
   end

   // ---------------------------------------------------------------
   // Interrupt: independent of main supply state
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) irq_out <= 1'b0;
      else irq_out <= flag_s & en_s;                       // RULE_04 RULE_19
   end

   // ---------------------------------------------------------------
   // Command byte: link domain capture, toggle crossing
   // ---------------------------------------------------------------
   cmd_byte_decode u_cmd (
      .serial_clk (serial_clk),
      .rstn       (rstn),
      .sel        (serial_sel),
      .serial_in  (serial_in),
      .cmd_q      (link_cmd),
      .cmd_tog_q  (link_tog)
   );

   logic tog_d1_q;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tog_d1_q  <= 1'b0;
         cmd_valid <= 1'b0;
         cmd_write <= 1'b0;
         cmd_addr  <= 7'h00;
      end else begin
         tog_d1_q  <= tog_s;
         // Commands during supply fail or power-up are dropped
         cmd_valid <= (tog_s ^ tog_d1_q) & live;           // RULE_10
         if ((tog_s ^ tog_d1_q) && live) begin
            // Byte is stable: its toggle crossed two flops after it
            cmd_write <= link_cmd[supervisor_pkg::CMD_DIR_BIT]
                         == supervisor_pkg::CMD_DIR_WRITE; // RULE_15
            cmd_addr  <= link_cmd[supervisor_pkg::CMD_ADDR_W-1:0]; // RULE_14
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) host_access_ok <= 1'b0;
      else host_access_ok <= live;                         // RULE_10
   end
endmodule

// file: tb/supervisor_monitor.sv
// Checker on the supervisor's ports, bound to every instance.
// Assumes rstn is low at time zero and crystal_in is a clean level.
module supervisor_monitor #(
   parameter int unsigned HOLD_TICKS = 4
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic crystal_in,
   input wire logic supply_ok,
   input wire logic supply_above_switch,
   input wire logic ram_enable_in_n,
   input wire logic upper_byte_gate_in_n,
   input wire logic lower_byte_gate_in_n,
   input wire logic high_byte_select_out_n,
   input wire logic low_byte_select_out_n,
   input wire logic on_backup,
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   input wire logic irq_flag,
   input wire logic irq_enable,
   input wire logic irq_out,
   input wire logic cmd_valid,
   input wire logic host_access_ok
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // Crystal edges counted while reset is pulled
   // ---------------------------------------------------------------
   logic        xtal_q;
   logic [19:0] ticks_q;
   logic        hi_go;
   logic        lo_go;
   logic        irq_go;
   assign hi_go  = !upper_byte_gate_in_n && !ram_enable_in_n;
   assign lo_go  = !lower_byte_gate_in_n && !ram_enable_in_n;
   assign irq_go = irq_flag && irq_enable;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         xtal_q  <= 1'b0;
         ticks_q <= '0;
      end else begin
         xtal_q <= crystal_in;
         if (!reset_pin_oe)
            ticks_q <= '0;
         else if (crystal_in && !xtal_q)
            ticks_q <= ticks_q + 20'h00001;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   hi_sel_gate_a: assert property (!high_byte_select_out_n |->
      $past(hi_go, 2) || $past(hi_go, 3) || $past(hi_go, 4))
      else $error("high byte select without its gates");
   lo_sel_gate_a: assert property (!low_byte_select_out_n |->
      $past(lo_go, 2) || $past(lo_go, 3) || $past(lo_go, 4))
      else $error("low byte select without its gates");
   irq_rise_a: assert property (irq_go [*6] |-> irq_out)
      else $error("interrupt missing while cause stands");
   irq_fall_a: assert property (!irq_go [*6] |-> !irq_out)
      else $error("interrupt stays without cause");
   fail_blocks_a: assert property (!supply_ok [*8] |->
      high_byte_select_out_n && low_byte_select_out_n && !host_access_ok)
      else $error("access open during supply fail");
   fail_resets_a: assert property (!supply_ok [*8] |-> reset_pin_oe)
      else $error("reset not pulled on supply fail");
   pin_drive_low_a: assert property (reset_pin_out == 1'b0)
      else $error("reset pin driven high");
   rst_hold_a: assert property ($fell(reset_pin_oe) |->
      ticks_q >= HOLD_TICKS - 1)
      else $error("reset pulse too short");
   backup_follow_a: assert property (
      $stable(supply_above_switch) [*5] |-> on_backup == !supply_above_switch)
      else $error("backup flag wrong");
   cmd_gated_a: assert property (cmd_valid |-> host_access_ok)
      else $error("command accepted while closed");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command pulse longer than one cycle");
endmodule

bind supervisor_ram_gate_cmd_decode supervisor_monitor #(
   .HOLD_TICKS(HOLD_TICKS)
) mon (
   .ref_clk(ref_clk), .rstn(rstn), .crystal_in(crystal_in),
   .supply_ok(supply_ok), .supply_above_switch(supply_above_switch),
   .ram_enable_in_n(ram_enable_in_n),
   .upper_byte_gate_in_n(upper_byte_gate_in_n),
   .lower_byte_gate_in_n(lower_byte_gate_in_n),
   .high_byte_select_out_n(high_byte_select_out_n),
   .low_byte_select_out_n(low_byte_select_out_n),
   .on_backup(on_backup), .reset_pin_out(reset_pin_out),
   .reset_pin_oe(reset_pin_oe), .irq_flag(irq_flag),
   .irq_enable(irq_enable), .irq_out(irq_out),
   .cmd_valid(cmd_valid), .host_access_ok(host_access_ok)
);

// file: tb/host_link.sv
// Host model: serial command frames on the link clock, watchdog kicks.
// Assumes ref_clk only paces the kicks; frames run on their own clock.
module host_link (
   input  wire logic ref_clk,
   input  wire logic kick_en,
   output logic      serial_clk,
   output logic      serial_sel,
   output logic      serial_in,
   output logic      watchdog_kick_n
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      serial_clk = 1'b0;
      serial_sel = 1'b0;
      serial_in = 1'b0;
      watchdog_kick_n = 1'b1;
   end
   // Kick well inside the shortened period, unless kicks are held off
   always begin
      repeat (150) @(posedge ref_clk);
      #1 watchdog_kick_n = !kick_en;
      repeat (3) @(posedge ref_clk);
      #1 watchdog_kick_n = 1'b1;
   end
   // Clock stands still between frames; data is not held after them
   task automatic send(input logic [7:0] b);
      #3.2 serial_sel = 1'b1;
      for (int i = 0; i < 8; i++) begin
         serial_in = b[i];
         #7.5 serial_clk = 1'b1;
         #7.5 serial_clk = 1'b0;
      end
      #7.5 serial_sel = 1'b0;
      serial_in = !serial_in;
   endtask
endmodule

// file: tb/supervisor_ram_gate_cmd_decode_bench.sv
// Self-checking bench for the supervisor with a host model on the link.
// Assumes a sped-up crystal; every count in the design but the crystal-loss timeout is in its ticks.
module supervisor_ram_gate_cmd_decode_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TICK = 200;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
   $display("wrong value at %0t got %h expected %h", $time, a, b); end end
   logic ref_clk, rstn, crystal_in, crystal_out, xtal_run, button, kick_en;
   logic supply_ok, supply_above_switch, ram_enable_in_n, on_backup;
   logic upper_byte_gate_in_n, lower_byte_gate_in_n, irq_flag, irq_enable;
   logic high_byte_select_out_n, low_byte_select_out_n, irq_out;
   logic watchdog_kick_n, reset_pin_in, reset_pin_out, reset_pin_oe;
   logic serial_clk, serial_sel, serial_in, cmd_valid, cmd_write;
   logic host_access_ok;
   logic [6:0] cmd_addr;
   logic [7:0] cmds [3] = '{8'h0c, 8'hff, 8'h80};
   // Rows: ram, upper, lower, flag, enable -> high, low, interrupt
   logic [7:0] rows [8] = '{8'h19, 8'h2a, 8'h54, 8'h66,
                            8'h9f, 8'ha6, 8'hdf, 8'hf6};
   int         bad_count, n_compared, n_cmd;
   // Open-drain pin with pull-up; the button shorts it low
   assign reset_pin_in = reset_pin_oe ? reset_pin_out : !button;
   supervisor_ram_gate_cmd_decode #(
      .WDOG_TICKS(8), .DEBOUNCE_TICKS(2), .HOLD_TICKS(4)
   ) dut (
      .ref_clk(ref_clk), .rstn(rstn), .crystal_in(crystal_in),
      .crystal_out(crystal_out), .supply_ok(supply_ok),
      .supply_above_switch(supply_above_switch),
      .ram_enable_in_n(ram_enable_in_n),
      .upper_byte_gate_in_n(upper_byte_gate_in_n),
      .lower_byte_gate_in_n(lower_byte_gate_in_n),
      .high_byte_select_out_n(high_byte_select_out_n),
      .low_byte_select_out_n(low_byte_select_out_n),
      .on_backup(on_backup), .watchdog_kick_n(watchdog_kick_n),
      .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
      .reset_pin_oe(reset_pin_oe), .irq_flag(irq_flag),
      .irq_enable(irq_enable), .irq_out(irq_out),
      .serial_clk(serial_clk), .serial_sel(serial_sel),
      .serial_in(serial_in), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .host_access_ok(host_access_ok));
   host_link hst (.ref_clk(ref_clk), .kick_en(kick_en),
      .serial_clk(serial_clk), .serial_sel(serial_sel),
      .serial_in(serial_in), .watchdog_kick_n(watchdog_kick_n));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = !ref_clk;
   end
   initial begin
      crystal_in = 1'b0;
      forever #1000 if (xtal_run) crystal_in = !crystal_in;
   end
   always @(posedge ref_clk)
      if (cmd_valid === 1'b1)
         n_cmd++;
   initial begin
      #600000;
      bad_count++;
      close_out();
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_oe(input logic v, input int lim);
      for (int i = 0; i < lim && reset_pin_oe !== v; i++)
         cyc(1);
   endtask
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {rstn, button, irq_flag, irq_enable} = 4'h0;
      {supply_ok, supply_above_switch, xtal_run, kick_en} = 4'hf;
      {ram_enable_in_n, upper_byte_gate_in_n, lower_byte_gate_in_n} = 3'h7;
      cyc(10);
      `CHK({high_byte_select_out_n, low_byte_select_out_n}, 2'h3)
      `CHK({reset_pin_oe, reset_pin_out}, 2'h2)
      `CHK({irq_out, cmd_valid, host_access_ok}, 3'h0)
      rstn = 1'b1;
      hst.send(8'h0c);
      cyc(2 * TICK);
      `CHK(n_cmd, 0)
      `CHK(reset_pin_oe, 1'b1)
      wait_oe(1'b0, 6 * TICK);
      `CHK({reset_pin_oe, host_access_ok}, 2'h1)
      for (int k = 0; k < 8; k++) begin
         {ram_enable_in_n, upper_byte_gate_in_n, lower_byte_gate_in_n,
          irq_flag, irq_enable} = rows[k][7:3];
         cyc(6);
         `CHK(high_byte_select_out_n, rows[k][2])
         `CHK(low_byte_select_out_n, rows[k][1])
         `CHK(irq_out, rows[k][0])
      end
      for (int k = 0; k < 3; k++) begin
         hst.send(cmds[k]);
         cyc(8);
         `CHK(n_cmd, k + 1)
         `CHK(cmd_addr, cmds[k][6:0])
         `CHK(cmd_write, cmds[k][7])
      end
      {supply_above_switch, irq_flag, irq_enable} = 3'h3;
      cyc(6);
      `CHK({on_backup, irq_out}, 2'h3)
      {supply_above_switch, irq_enable} = 2'h2;
      cyc(6);
      `CHK({on_backup, irq_out}, 2'h0)
      kick_en = 1'b0;
      cyc(6 * TICK);
      `CHK(reset_pin_oe, 1'b0)
      wait_oe(1'b1, 4 * TICK);
      `CHK(reset_pin_oe, 1'b1)
      kick_en = 1'b1;
      wait_oe(1'b0, 6 * TICK);
      button = 1'b1;
      wait_oe(1'b1, 4 * TICK);
      `CHK(reset_pin_oe, 1'b1)
      button = 1'b0;
      cyc(2 * TICK);
      `CHK(reset_pin_oe, 1'b1)
      wait_oe(1'b0, 6 * TICK);
      {ram_enable_in_n, upper_byte_gate_in_n, lower_byte_gate_in_n} = 3'h0;
      cyc(6);
      `CHK({high_byte_select_out_n, low_byte_select_out_n}, 2'h0)
      supply_ok = 1'b0;
      cyc(8);
      `CHK({high_byte_select_out_n, low_byte_select_out_n}, 2'h3)
      `CHK({reset_pin_oe, host_access_ok}, 2'h2)
      hst.send(8'h0b);
      cyc(8);
      `CHK(n_cmd, 3)
      supply_ok = 1'b1;
      cyc(2 * TICK);
      `CHK(reset_pin_oe, 1'b1)
      wait_oe(1'b0, 6 * TICK);
      `CHK(reset_pin_oe, 1'b0)
      xtal_run = 1'b0;
      wait_oe(1'b1, 13000);
      `CHK({reset_pin_oe, host_access_ok}, 2'h2)
      `CHK(crystal_out, !crystal_in)
      rstn = 1'b0;
      cyc(3);
      `CHK({reset_pin_oe, cmd_valid}, 2'h2)
      close_out();
   end
endmodule
